// >>> rtl/salt_pkg.sv
package salt_pkg;

	// ******************************
	// table geometry and key layout
	// ******************************
	localparam int VID_W        = 12;
	localparam int ADDR_W       = 48;
	localparam int KEY_W        = VID_W + ADDR_W;
	localparam int STATIC_MAX   = 64;
	localparam int TABLE_MAX    = 8192;

	// ******************************
	// aging
	// ******************************
	localparam int AGE_MIN_S    = 10;
	localparam int AGE_MAX_S    = 1000000;
	localparam int AGE_RESET_S  = 300;
	localparam int AGE_W        = 20;
	localparam int CLK_HZ       = 10000000;
	localparam int SEC_CYCLES   = CLK_HZ;

	// learning modes of a port
	typedef enum logic [1:0] {
		SALT_LRN_AUTO,
		SALT_LRN_DISABLE,
		SALT_LRN_SECURE
	} salt_lrn_t;

	// management operations
	typedef enum logic [2:0] {
		SALT_OP_NONE,
		SALT_OP_STATIC_ADD,
		SALT_OP_STATIC_DEL,
		SALT_OP_READ_KEY,
		SALT_OP_GET_NEXT,
		SALT_OP_FLUSH
	} salt_op_t;

	// one frame header presented by ingress
	typedef struct packed {
		logic [VID_W-1:0]  vid;
		logic [ADDR_W-1:0] dest_station_addr;
		logic [ADDR_W-1:0] src_station_addr;
		logic [3:0]        port;
	} salt_frame_t;

endpackage : salt_pkg

// >>> rtl/salt_table.sv
// ******************************
// station address learning table
// ******************************
module salt_table
	import salt_pkg::*;
#(
	parameter int PORTS      = 10,
	parameter int DEPTH      = TABLE_MAX,
	parameter int SEC_CYC    = SEC_CYCLES
) (
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  srst_in,
	// frame lookup from ingress
	input  wire logic                  frm_valid_in,
	input  wire salt_frame_t           frm_in,
	input  wire logic [PORTS-1:0]      vlan_members_in,
	output logic                       fwd_valid_out,
	output logic [PORTS-1:0]           fwd_ports_out,
	output logic                       fwd_drop_out,
	output logic                       fwd_hit_out,
	// configuration
	input  wire logic                  age_wr_in,
	input  wire logic [AGE_W-1:0]      age_secs_in,
	input  wire logic                  aging_off_in,
	input  wire logic                  mode_wr_in,
	input  wire logic [3:0]            mode_port_in,
	input  wire salt_lrn_t             mode_in,
	input  wire logic [PORTS-1:0]      mode_owned_in,
	output logic [AGE_W-1:0]           age_secs_out,
	output logic                       mode_blocked_out,
	// management operations
	input  wire logic                  op_valid_in,
	input  wire salt_op_t              op_in,
	input  wire logic [VID_W-1:0]      op_vid_in,
	input  wire logic [ADDR_W-1:0]     op_addr_in,
	input  wire logic [PORTS-1:0]      op_members_in,
	output logic                       op_done_out,
	output logic                       op_found_out,
	output logic                       op_end_out,
	output logic                       op_static_out,
	output logic [VID_W-1:0]           op_vid_out,
	output logic [ADDR_W-1:0]          op_addr_out,
	output logic [PORTS-1:0]           op_members_out
);

	// ******************************
	// storage
	// ******************************
	// a register array this deep is costly; small builds shrink DEPTH
	logic              e_valid   [DEPTH];
	logic              e_static  [DEPTH];
	logic [KEY_W-1:0]  e_key     [DEPTH];
	logic [PORTS-1:0]  e_members [DEPTH];
	logic [AGE_W-1:0]  e_idle    [DEPTH];
	salt_lrn_t         lrn_mode  [PORTS];
	logic [AGE_W-1:0]  age_secs;
	logic [31:0]       sec_cnt;
	logic              tick;

	// ******************************
	// combinational searches
	// ******************************
	logic [KEY_W-1:0]  frm_dkey;
	logic [KEY_W-1:0]  frm_skey;
	logic [KEY_W-1:0]  op_key;
	logic              d_hit;
	logic [PORTS-1:0]  d_members;
	logic              s_hit;
	logic              s_is_static;
	int                s_idx;
	int                free_idx;
	int                op_idx;
	int                nxt_idx;
	int                static_cnt;
	int                dyn_cnt;
	logic [KEY_W-1:0]  best_key;

	assign frm_dkey = {frm_in.vid, frm_in.dest_station_addr};
	assign frm_skey = {frm_in.vid, frm_in.src_station_addr};
	assign op_key   = {op_vid_in, op_addr_in};

	// one pass over the array answers every lookup in the same cycle
	always_comb begin
		d_hit       = 1'b0;
		d_members   = '0;
		s_hit       = 1'b0;
		s_is_static = 1'b0;
		s_idx       = 0;
		free_idx    = -1;
		op_idx      = -1;
		nxt_idx     = -1;
		static_cnt  = 0;
		dyn_cnt     = 0;
		best_key    = '1;
		for (int i = 0; i < DEPTH; i++) begin
			if (e_valid[i]) begin
				static_cnt += int'(e_static[i]);
				dyn_cnt    += int'(!e_static[i]); // watched after a flush
				if (e_key[i] == frm_dkey) begin
					d_hit     = 1'b1;
					d_members = e_members[i];
				end
				if (e_key[i] == frm_skey) begin
					s_hit       = 1'b1;
					s_is_static = e_static[i];
					s_idx       = i;
				end
				if (e_key[i] == op_key) begin
					op_idx = i;
				end
				// smallest key not below the request, or strictly above it for SALT_OP_GET_NEXT
				if (op_in == SALT_OP_GET_NEXT ? e_key[i] > op_key : e_key[i] >= op_key) begin
					if (nxt_idx < 0 || e_key[i] < best_key) begin
						nxt_idx  = i;
						best_key = e_key[i];
					end
				end
			end else if (free_idx < 0) begin
				free_idx = i;
			end
		end
	end

	// ******************************
	// one-second tick
	// ******************************
	always_ff @(posedge clk_in) begin
		if (srst_in || sec_cnt == 32'(SEC_CYC - 1)) begin
			sec_cnt <= '0;
		end else begin
			sec_cnt <= sec_cnt + 32'h1;
		end
	end
	assign tick = (sec_cnt == 32'(SEC_CYC - 1));

	// ******************************
	// configuration
	// ******************************
	// out-of-range age writes are ignored
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			age_secs <= AGE_W'(AGE_RESET_S);
		end else if (age_wr_in && age_secs_in >= AGE_W'(AGE_MIN_S)
				&& age_secs_in <= AGE_W'(AGE_MAX_S)) begin
			age_secs <= age_secs_in;
		end
	end
	assign age_secs_out = age_secs;

	// a port whose mode is owned elsewhere refuses management writes
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			mode_blocked_out <= 1'b0;
			for (int p = 0; p < PORTS; p++) begin
				lrn_mode[p] <= SALT_LRN_AUTO;
			end
		end else begin
			mode_blocked_out <= 1'b0;
			if (mode_wr_in && mode_port_in < 4'(PORTS)) begin
				if (mode_owned_in[mode_port_in]) begin
					mode_blocked_out <= 1'b1;
				end else begin
					lrn_mode[mode_port_in] <= mode_in;
				end
			end
		end
	end

	// ******************************
	// forwarding decision
	// ******************************
	salt_lrn_t         in_mode;
	logic [PORTS-1:0]  in_bit;
	assign in_mode = lrn_mode[frm_in.port];
	assign in_bit  = PORTS'(1) << frm_in.port;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			fwd_valid_out <= 1'b0;
			fwd_ports_out <= '0;
			fwd_drop_out  <= 1'b0;
			fwd_hit_out   <= 1'b0;
		end else begin
			fwd_valid_out <= frm_valid_in;
			fwd_hit_out   <= d_hit;
			// secure ports pass only sources known statically
			fwd_drop_out  <= frm_valid_in && in_mode == SALT_LRN_SECURE
				&& !(s_hit && s_is_static);
			if (d_hit) begin
				fwd_ports_out <= d_members;
			end else begin
				fwd_ports_out <= vlan_members_in & ~in_bit;
			end
		end
	end

	// ******************************
	// table maintenance
	// ******************************
	// management has priority over learning in a shared cycle; learning retries
	// on the next frame from that source, which is cheaper than a second port
	logic op_go;
	logic learn_go;
	assign op_go    = op_valid_in && op_in != SALT_OP_NONE;
	assign learn_go = frm_valid_in && in_mode == SALT_LRN_AUTO;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				e_valid[i]   <= 1'b0;
				e_static[i]  <= 1'b0;
				e_key[i]     <= '0;
				e_members[i] <= '0;
				e_idle[i]    <= '0;
			end
		end else begin
			// aging sweep once per second
			if (tick) begin
				for (int i = 0; i < DEPTH; i++) begin
					if (e_valid[i] && !e_static[i] && !aging_off_in) begin
						if (e_idle[i] + AGE_W'(1) >= age_secs) begin
							e_valid[i] <= 1'b0;
						end else begin
							e_idle[i] <= e_idle[i] + AGE_W'(1);
						end
					end
				end
			end
			if (op_go) begin
				case (op_in)
					SALT_OP_STATIC_ADD: begin
						if (op_idx >= 0 && (e_static[op_idx] || static_cnt < STATIC_MAX)) begin
							e_static[op_idx]  <= 1'b1;
							e_members[op_idx] <= op_members_in;
							e_valid[op_idx]   <= 1'b1;
						end else if (free_idx >= 0 && static_cnt < STATIC_MAX) begin
							e_valid[free_idx]   <= 1'b1;
							e_static[free_idx]  <= 1'b1;
							e_key[free_idx]     <= op_key;
							e_members[free_idx] <= op_members_in;
							e_idle[free_idx]    <= '0;
						end
					end
					SALT_OP_STATIC_DEL: begin
						if (op_idx >= 0 && e_static[op_idx]) begin
							e_valid[op_idx] <= 1'b0;
						end
					end
					SALT_OP_FLUSH: begin
						for (int i = 0; i < DEPTH; i++) begin
							if (!e_static[i]) begin
								e_valid[i] <= 1'b0;
							end
						end
					end
					default: begin
					end
				endcase
			end else if (learn_go) begin
				if (s_hit && !s_is_static) begin
					e_idle[s_idx]    <= '0;
					e_valid[s_idx]   <= 1'b1;
					e_members[s_idx] <= in_bit;
				end else if (!s_hit && free_idx >= 0) begin
					e_valid[free_idx]   <= 1'b1;
					e_static[free_idx]  <= 1'b0;
					e_key[free_idx]     <= frm_skey;
					e_members[free_idx] <= in_bit;
					e_idle[free_idx]    <= '0;
				end
			end
		end
	end

	// ******************************
	// read answers
	// ******************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			op_done_out    <= 1'b0;
			op_found_out   <= 1'b0;
			op_end_out     <= 1'b0;
			op_static_out  <= 1'b0;
			op_vid_out     <= '0;
			op_addr_out    <= '0;
			op_members_out <= '0;
		end else begin
			op_done_out  <= op_go;
			op_found_out <= 1'b0;
			op_end_out   <= 1'b0;
			if (op_go && (op_in == SALT_OP_READ_KEY || op_in == SALT_OP_GET_NEXT)) begin
				if (nxt_idx >= 0) begin
					op_found_out   <= 1'b1;
					op_static_out  <= e_static[nxt_idx];
					op_vid_out     <= e_key[nxt_idx][KEY_W-1 -: VID_W];
					op_addr_out    <= e_key[nxt_idx][ADDR_W-1:0];
					op_members_out <= e_members[nxt_idx];
				end else begin
					op_end_out <= 1'b1;
				end
			end
		end
	end

	// ******************************
	// checks
	// ******************************
	a_age_reset_val: assert property (@(posedge clk_in) $fell(srst_in) |-> age_secs == AGE_W'(AGE_RESET_S)) else $error("age not at reset value");
	a_age_in_range: assert property (@(posedge clk_in) disable iff (srst_in) age_secs >= AGE_W'(AGE_MIN_S) && age_secs <= AGE_W'(AGE_MAX_S)) else $error("age out of range");
	a_owned_blocks: assert property (@(posedge clk_in) disable iff (srst_in) mode_wr_in && mode_port_in < 4'(PORTS) && mode_owned_in[mode_port_in] |=> mode_blocked_out) else $error("owned write not blocked");
	a_op_answer: assert property (@(posedge clk_in) disable iff (srst_in) op_go && (op_in == SALT_OP_READ_KEY || op_in == SALT_OP_GET_NEXT) |=> op_done_out && (op_found_out ^ op_end_out)) else $error("read answer malformed");
	a_fwd_hit: assert property (@(posedge clk_in) disable iff (srst_in) frm_valid_in && d_hit |=> fwd_ports_out == $past(d_members)) else $error("hit not forwarded");
	a_miss_flood: assert property (@(posedge clk_in) disable iff (srst_in) frm_valid_in && !d_hit |=> fwd_ports_out == $past(vlan_members_in & ~in_bit)) else $error("miss not flooded");
	a_secure_drop: assert property (@(posedge clk_in) disable iff (srst_in) frm_valid_in && in_mode == SALT_LRN_SECURE && !s_hit |=> fwd_drop_out) else $error("secure miss not dropped");
	a_static_cap: assert property (@(posedge clk_in) disable iff (srst_in) static_cnt <= STATIC_MAX) else $error("too many statics");
	a_flush_clean: assert property (@(posedge clk_in) disable iff (srst_in) op_go && op_in == SALT_OP_FLUSH |=> dyn_cnt == 0) else $error("flush left dynamic");

endmodule : salt_table

// >>> tb/salt_ingress_model.sv
// ******************************
// ingress side: frame header source
// ******************************
module salt_ingress_model
	import salt_pkg::*;
#(
	parameter int PORTS = 10
) (
	// clock
	input  wire logic         clk_in,
	// frame header towards the table
	output logic              frm_valid_out,
	output salt_frame_t       frm_out,
	output logic [PORTS-1:0]  vlan_members_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle until the first frame
	initial begin
		frm_valid_out = 1'h0;
		frm_out = '0;
		vlan_members_out = '0;
	end

	// one-cycle header; fields are scrambled after so stale data never matches
	task send(input logic [VID_W-1:0] v, input logic [ADDR_W-1:0] d, input logic [ADDR_W-1:0] s,
		input logic [3:0] p, input logic [PORTS-1:0] m);
		@(posedge clk_in);
		#1;
		frm_valid_out = 1'h1;
		frm_out = {v, d, s, p};
		vlan_members_out = m;
		@(posedge clk_in);
		#1;
		frm_valid_out = 1'h0;
		frm_out = ~frm_out;
		vlan_members_out = ~m;
	endtask : send
endmodule : salt_ingress_model

// >>> tb/tb_salt_table.sv
module tb_salt_table;
	timeunit 1ns;
	timeprecision 1ns;
	import salt_pkg::*;

	// ******************************
	// signals
	// ******************************
	logic                clk_in = 1'h0;
	logic                srst_in = 1'h1;
	logic                frm_valid_in;
	salt_frame_t         frm_in;
	logic [9:0]          vlan_members_in;
	logic                fwd_valid_out, fwd_drop_out, fwd_hit_out;
	logic [9:0]          fwd_ports_out;
	logic                age_wr_in = 1'h0;
	logic [AGE_W-1:0]    age_secs_in = '0;
	logic                aging_off_in = 1'h0;
	logic                mode_wr_in = 1'h0;
	logic [3:0]          mode_port_in = '0;
	salt_lrn_t           mode_in = SALT_LRN_AUTO;
	logic [9:0]          mode_owned_in = '0;
	logic [AGE_W-1:0]    age_secs_out;
	logic                mode_blocked_out;
	logic                op_valid_in = 1'h0;
	salt_op_t            op_in = SALT_OP_NONE;
	logic [VID_W-1:0]    op_vid_in = '0;
	logic [ADDR_W-1:0]   op_addr_in = '0;
	logic [9:0]          op_members_in = '0;
	logic                op_done_out, op_found_out, op_end_out, op_static_out;
	logic [VID_W-1:0]    op_vid_out;
	logic [ADDR_W-1:0]   op_addr_out;
	logic [9:0]          op_members_out;
	int                  err_total = 0;
	int                  n_compared = 0;

	// short second so aging fits in a few hundred cycles
	always #50 clk_in = ~clk_in;

	salt_ingress_model #(.PORTS(10)) salt_ingress_model_inst (.clk_in(clk_in),
		.frm_valid_out(frm_valid_in), .frm_out(frm_in), .vlan_members_out(vlan_members_in));

	salt_table #(.PORTS(10), .DEPTH(64), .SEC_CYC(10)) salt_table_inst (.clk_in(clk_in),
		.srst_in(srst_in), .frm_valid_in(frm_valid_in), .frm_in(frm_in),
		.vlan_members_in(vlan_members_in), .fwd_valid_out(fwd_valid_out),
		.fwd_ports_out(fwd_ports_out), .fwd_drop_out(fwd_drop_out), .fwd_hit_out(fwd_hit_out),
		.age_wr_in(age_wr_in), .age_secs_in(age_secs_in), .aging_off_in(aging_off_in),
		.mode_wr_in(mode_wr_in), .mode_port_in(mode_port_in), .mode_in(mode_in),
		.mode_owned_in(mode_owned_in), .age_secs_out(age_secs_out),
		.mode_blocked_out(mode_blocked_out), .op_valid_in(op_valid_in), .op_in(op_in),
		.op_vid_in(op_vid_in), .op_addr_in(op_addr_in), .op_members_in(op_members_in),
		.op_done_out(op_done_out), .op_found_out(op_found_out), .op_end_out(op_end_out),
		.op_static_out(op_static_out), .op_vid_out(op_vid_out), .op_addr_out(op_addr_out),
		.op_members_out(op_members_out));

	// ******************************
	// tasks
	// ******************************
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// age write; out-of-range values must leave the old age
	task aw(input logic [AGE_W-1:0] v, input logic [AGE_W-1:0] e);
		@(posedge clk_in);
		#1;
		age_wr_in = 1'h1;
		age_secs_in = v;
		@(posedge clk_in);
		#1;
		age_wr_in = 1'h0;
		chk(age_secs_out, e);
	endtask : aw

	task mw(input logic [3:0] p, input salt_lrn_t m, input logic blk);
		@(posedge clk_in);
		#1;
		mode_wr_in = 1'h1;
		mode_port_in = p;
		mode_in = m;
		@(posedge clk_in);
		#1;
		mode_wr_in = 1'h0;
		chk(mode_blocked_out, blk);
	endtask : mw

	task op(input salt_op_t o, input logic [11:0] v, input logic [47:0] a, input logic [9:0] m);
		@(posedge clk_in);
		#1;
		op_valid_in = 1'h1;
		op_in = o;
		op_vid_in = v;
		op_addr_in = a;
		op_members_in = m;
		@(posedge clk_in);
		#1;
		op_valid_in = 1'h0;
		chk(op_done_out, 1'h1);
	endtask : op

	// read result: key, members and type, or the end flag alone
	task rd(input salt_op_t o, input logic [11:0] v, input logic [47:0] a, input logic [11:0] ev,
		input logic [47:0] ea, input logic [9:0] em, input logic es, input logic ee);
		op(o, v, a, 10'h000);
		chk(op_end_out, ee);
		chk(op_found_out, !ee);
		if (!ee) begin
			chk({op_vid_out, op_addr_out}, {ev, ea});
			chk({op_members_out, op_static_out}, {em, es});
		end
	endtask : rd

	// frame in VLAN 1 with every port a member; egress only checked when not dropped
	task frm(input logic [47:0] d, input logic [47:0] s, input logic [3:0] p, input logic [9:0] ep,
		input logic eh, input logic ed);
		salt_ingress_model_inst.send(12'h001, d, s, p, 10'h3FF);
		chk(fwd_valid_out, 1'h1);
		chk(fwd_drop_out, ed);
		if (!ed) begin
			chk(fwd_ports_out, ep);
			chk(fwd_hit_out, eh);
		end
	endtask : frm

	task conclude();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	// ******************************
	// tests
	// ******************************
	initial begin
		repeat (8) @(posedge clk_in);
		#1;
		srst_in = 1'h0;
		chk(age_secs_out, 20'h0012C);
		aw(20'h00009, 20'h0012C);
		aw(20'hF4241, 20'h0012C);
		aw(20'h0000A, 20'h0000A);
		aw(20'hF4240, 20'hF4240);
		$display("test age done");
		op(SALT_OP_STATIC_ADD, 12'h001, 48'h10, 10'h001);
		op(SALT_OP_STATIC_ADD, 12'h001, 48'h30, 10'h002);
		op(SALT_OP_STATIC_ADD, 12'h000, 48'hFF, 10'h100);
		frm(48'h10, 48'h20, 4'h2, 10'h001, 1'h1, 1'h0);
		frm(48'h20, 48'h21, 4'h1, 10'h004, 1'h1, 1'h0);
		frm(48'h99, 48'h20, 4'h3, 10'h3F7, 1'h0, 1'h0);
		frm(48'h20, 48'h22, 4'h1, 10'h008, 1'h1, 1'h0);
		$display("test lookup done");
		mode_owned_in = 10'h080;
		mw(4'h7, SALT_LRN_SECURE, 1'h1);
		mw(4'h4, SALT_LRN_DISABLE, 1'h0);
		mw(4'h5, SALT_LRN_SECURE, 1'h0);
		mw(4'h6, SALT_LRN_AUTO, 1'h0);
		frm(48'h99, 48'h25, 4'h7, 10'h37F, 1'h0, 1'h0);
		frm(48'h25, 48'h27, 4'h1, 10'h080, 1'h1, 1'h0);
		frm(48'h23, 48'h40, 4'h4, 10'h3EF, 1'h0, 1'h0);
		frm(48'h40, 48'h24, 4'h1, 10'h3FD, 1'h0, 1'h0);
		frm(48'h22, 48'h50, 4'h5, 10'h000, 1'h0, 1'h1);
		frm(48'h22, 48'h10, 4'h5, 10'h002, 1'h1, 1'h0);
		frm(48'h50, 48'h26, 4'h1, 10'h3FD, 1'h0, 1'h0);
		$display("test mode done");
		rd(SALT_OP_READ_KEY, 12'h000, 48'h0, 12'h000, 48'hFF, 10'h100, 1'h1, 1'h0);
		rd(SALT_OP_GET_NEXT, 12'h000, 48'hFF, 12'h001, 48'h10, 10'h001, 1'h1, 1'h0);
		rd(SALT_OP_READ_KEY, 12'h001, 48'h11, 12'h001, 48'h20, 10'h008, 1'h0, 1'h0);
		rd(SALT_OP_GET_NEXT, 12'h001, 48'h30, 12'h000, 48'h0, 10'h000, 1'h0, 1'h1);
		op(SALT_OP_FLUSH, 12'h000, 48'h0, 10'h000);
		rd(SALT_OP_READ_KEY, 12'h001, 48'h11, 12'h001, 48'h30, 10'h002, 1'h1, 1'h0);
		$display("test read done");
		aw(20'h0000A, 20'h0000A);
		aging_off_in = 1'h1;
		frm(48'h99, 48'h61, 4'h2, 10'h3FB, 1'h0, 1'h0);
		repeat (300) @(posedge clk_in);
		frm(48'h61, 48'h62, 4'h1, 10'h004, 1'h1, 1'h0);
		aging_off_in = 1'h0;
		repeat (300) @(posedge clk_in);
		frm(48'h61, 48'h63, 4'h1, 10'h3FD, 1'h0, 1'h0);
		frm(48'h30, 48'h64, 4'h1, 10'h002, 1'h1, 1'h0);
		// a deleted static entry no longer steers frames
		op(SALT_OP_STATIC_DEL, 12'h001, 48'h30, 10'h000);
		frm(48'h30, 48'h65, 4'h1, 10'h3FD, 1'h0, 1'h0);
		$display("test aging done");
		conclude();
	end

	// the tests need about 680 cycles
	initial begin
		repeat (3000) @(posedge clk_in);
		err_total++;
		$display("BAD %0t watchdog expired", $time);
		conclude();
	end
endmodule : tb_salt_table
